// ===== hw/otp_cfg_pkg.sv
package otp_cfg_pkg;

  // ==========================================================
  // Special-function register addresses
  localparam logic [7:0] OTP_STATUS_ADDR = 8'hF8;
  localparam logic [7:0] OTP_PROTECT_CONFIG_ADDR = 8'hF9;
  localparam logic [7:0] OTP_COMMAND_ADDR = 8'hFA;

  // ==========================================================
  // Status register fields and fixed register values
  localparam int WEN_BIT = 5;
  localparam int BUSY_BIT = 4;
  localparam int INFO_SEL_BIT = 3;
  localparam int LOCK_BIT = 2;
  localparam logic [7:0] PROTECT_CONFIG_VALUE = 8'hFF;
  localparam logic [7:0] COMMAND_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Information page layout
  localparam int INFO_BYTES = 512;
  localparam int INFO_AW = 9;
  localparam logic [8:0] ID_START = 9'h00B;
  localparam int ID_BYTES = 5;
  localparam logic [8:0] UNPROTECTED_PAGE_COUNT_BYTE = 9'h020;
  localparam logic [8:0] DATA_AREA_ENABLE_BYTE = 9'h021;
  localparam logic [8:0] LOCK_BYTE = 9'h023;
  localparam logic [8:0] USER_START = 9'h100;
  localparam int USER_BYTES = 256;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] DATA_AREA_ENABLE_VALUE = 8'h00;
  localparam logic [7:0] BURN_ALL = 8'hFF;

  // ==========================================================
  // Serial programmer opcodes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDIS = 8'h04;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_LOCK = 8'h85;

  // ==========================================================
  // Write unlock sequence
  localparam logic [7:0] UNLOCK_FIRST = 8'hAA;
  localparam logic [7:0] UNLOCK_SECOND = 8'h55;
  localparam logic [6:0] UNLOCK_COUNT = 7'h7F;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int PROG_TIME_NS = 100000;
  localparam int PROG_CYC = (PROG_TIME_NS / 1000) * (CLK_HZ / 1000000);
  localparam int PROG_CW = 16;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_PROG = 2'b11
  } otp_state_t;

endpackage

// ===== hw/otp_config_status_protect.sv
`timescale 1ns/1ps
`default_nettype none

module otp_config_status_protect
  import otp_cfg_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  // Arbitrary per-device number
  parameter logic [39:0] DEVICE_NUMBER = 40'h5A3C96E10F
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Supply monitor
  input wire logic pwr_fail_i,
  // Special-function register port
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Microcontroller programming request
  input wire logic mcu_prog_i,
  input wire logic [15:0] mcu_addr_i,
  input wire logic [7:0] mcu_data_i,
  // Serial programmer command hook
  input wire logic ser_cmd_i,
  input wire logic [7:0] ser_opcode_i,
  input wire logic [15:0] ser_addr_i,
  input wire logic [7:0] ser_data_i,
  // Info page read port
  input wire logic [8:0] info_rd_addr_i,
  output logic [7:0] info_rdata_o,
  // Main array programming port
  output logic main_wr_o,
  output logic [15:0] main_addr_o,
  output logic [7:0] main_data_o,
  // Control state
  output logic main_readback_lock_o,
  output logic interface_busy_o,
  output logic info_page_select_o
);

  // ==========================================================
  // Declarations
  otp_state_t state_r;
  logic [PROG_CW-1:0] prog_cnt_r;
  logic pf_meta_r;
  logic pf_sync_r;
  logic wen_r;
  logic info_sel_r;
  logic lock_r;
  logic busy_r;
  logic [7:0] otp_command_reg_r;
  logic [6:0] unlock_cnt_r;
  logic armed_r;
  logic open_r;
  // Bits that have been programmed; kept across reset like real OTP
  logic [7:0] burn_q [INFO_BYTES] = '{default: 8'h00};

  logic ser_prog;
  logic ser_lock;
  logic req;
  logic req_info;
  logic [15:0] req_addr;
  logic [7:0] req_data;
  logic allowed;
  logic go;
  logic unlock_ok;
  logic status_wr;
  logic command_wr;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] factory_byte(input logic [8:0] a);
    logic [7:0] v;
    int idx;
    v = ERASED;
    idx = int'(a) - int'(ID_START);
    if (idx >= 0 && idx < ID_BYTES) begin
      v = DEVICE_NUMBER[8*idx +: 8];
    end
    if (a == DATA_AREA_ENABLE_BYTE) begin
      v = DATA_AREA_ENABLE_VALUE;
    end
    return v;
  endfunction

  function automatic logic [7:0] info_value(input logic [8:0] a);
    return factory_byte(a) & ~burn_q[a];
  endfunction

  // ==========================================================
  // Supply fail synchroniser
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pf_meta_r <= 1'b0;
      pf_sync_r <= 1'b0;
    end else if (ce_i) begin
      pf_meta_r <= pwr_fail_i;
      pf_sync_r <= pf_meta_r;
    end
  end

  // ==========================================================
  // Request selection and permission
  assign ser_prog = ser_cmd_i && (ser_opcode_i == CMD_PROGRAM);
  assign ser_lock = ser_cmd_i && (ser_opcode_i == CMD_LOCK);
  assign status_wr = sfr_wr_i && (sfr_addr_i == OTP_STATUS_ADDR);
  assign command_wr = sfr_wr_i && (sfr_addr_i == OTP_COMMAND_ADDR);
  assign unlock_ok = open_r && (unlock_cnt_r != 7'h00);

  // Serial side wins when both arrive together
  always_comb begin
    req = ser_prog || ser_lock || mcu_prog_i;
    req_info = info_sel_r;
    req_addr = mcu_addr_i;
    req_data = mcu_data_i;
    allowed = 1'b0;
    if (ser_lock) begin
      req_info = 1'b1;
      req_addr = {7'h00, LOCK_BYTE};
      req_data = 8'h00;
      allowed = 1'b1;
    end else if (ser_prog) begin
      req_addr = ser_addr_i;
      req_data = ser_data_i;
      // Serial may program any info byte, user region included
      allowed = info_sel_r ? (ser_addr_i < 16'(INFO_BYTES)) : !lock_r;
    end else if (mcu_prog_i) begin
      allowed = info_sel_r ? (mcu_addr_i == {7'h00, LOCK_BYTE})
                           : !lock_r;
    end
  end

  // No trace is kept of a discarded request
  assign go = req && allowed && wen_r && !pf_sync_r
              && (state_r == ST_IDLE);

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_LOAD;
      prog_cnt_r <= '0;
    end else if (ce_i) begin
      unique case (state_r)
        ST_LOAD: begin
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          if (go) begin
            state_r <= ST_PROG;
            prog_cnt_r <= PROG_CW'(PROG_CYCLES - 1);
          end
        end
        ST_PROG: begin
          // Supply fail is not looked at here, the write finishes
          if (prog_cnt_r == '0) begin
            state_r <= ST_IDLE;
          end else begin
            prog_cnt_r <= prog_cnt_r - 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b1;
    end else if (ce_i) begin
      busy_r <= go || (state_r == ST_PROG && prog_cnt_r != '0);
    end
  end

  // ==========================================================
  // Lock flag
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r == ST_LOAD) begin
        lock_r <= (info_value(LOCK_BYTE) != ERASED);
      end else if (go && ser_lock) begin
        lock_r <= 1'b1;
      end
      // Microcontroller writes to byte 0x23 wait for the next load
    end
  end

  // ==========================================================
  // Info page array, programming only clears bits
  always_ff @(posedge clk_i) begin
    if (ce_i && go && req_info) begin
      burn_q[req_addr[INFO_AW-1:0]] <= burn_q[req_addr[INFO_AW-1:0]]
                                       | ~req_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      info_rdata_o <= ERASED;
    end else if (ce_i) begin
      info_rdata_o <= info_value(info_rd_addr_i);
    end
  end

  // ==========================================================
  // Main array write strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_wr_o <= 1'b0;
      main_addr_o <= 16'h0000;
      main_data_o <= ERASED;
    end else if (ce_i) begin
      main_wr_o <= go && !req_info;
      if (go && !req_info) begin
        main_addr_o <= req_addr;
        main_data_o <= req_data;
      end
    end
  end

  // ==========================================================
  // Write enable
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wen_r <= 1'b0;
    end else if (ce_i) begin
      if (ser_cmd_i) begin
        unique case (ser_opcode_i)
          CMD_WREN: wen_r <= 1'b1;
          CMD_WRDIS: wen_r <= 1'b0;
          CMD_WRSR: wen_r <= ser_data_i[WEN_BIT];
          CMD_PROGRAM, CMD_LOCK: wen_r <= 1'b0;
          default: wen_r <= wen_r;
        endcase
      end else if (status_wr) begin
        // Clearing needs no unlock
        if (!sfr_wdata_i[WEN_BIT]) begin
          wen_r <= 1'b0;
        end else if (unlock_ok) begin
          wen_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Info page select
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      info_sel_r <= 1'b0;
    end else if (ce_i) begin
      if (ser_cmd_i && ser_opcode_i == CMD_WRSR) begin
        info_sel_r <= ser_data_i[INFO_SEL_BIT];
      end else if (status_wr) begin
        info_sel_r <= sfr_wdata_i[INFO_SEL_BIT];
      end
    end
  end

  // ==========================================================
  // Command register and unlock window
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      otp_command_reg_r <= COMMAND_RESET;
    end else if (ce_i && command_wr) begin
      otp_command_reg_r <= sfr_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      unlock_cnt_r <= 7'h00;
      armed_r <= 1'b0;
      open_r <= 1'b0;
    end else if (ce_i) begin
      if (command_wr && sfr_wdata_i == UNLOCK_FIRST) begin
        unlock_cnt_r <= UNLOCK_COUNT;
        armed_r <= 1'b1;
        open_r <= 1'b0;
      end else if (command_wr && sfr_wdata_i == UNLOCK_SECOND
                   && armed_r && unlock_cnt_r != 7'h00) begin
        unlock_cnt_r <= UNLOCK_COUNT;
        armed_r <= 1'b0;
        open_r <= 1'b1;
      end else if (command_wr) begin
        // Any other value breaks the sequence
        unlock_cnt_r <= 7'h00;
        armed_r <= 1'b0;
        open_r <= 1'b0;
      end else if (unlock_cnt_r != 7'h00) begin
        unlock_cnt_r <= unlock_cnt_r - 7'h01;
      end else begin
        armed_r <= 1'b0;
        open_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register read-back, one cycle latency
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= UNMAPPED_READ;
    end else if (ce_i) begin
      unique case (sfr_addr_i)
        OTP_STATUS_ADDR: begin
          sfr_rdata_o <= {2'b00, wen_r, busy_r, info_sel_r, lock_r,
                          2'b00};
        end
        OTP_PROTECT_CONFIG_ADDR: sfr_rdata_o <= PROTECT_CONFIG_VALUE;
        OTP_COMMAND_ADDR: begin
          sfr_rdata_o <= otp_command_reg_r;
        end
        default: sfr_rdata_o <= UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================================
  // Status mirrors
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_readback_lock_o <= 1'b0;
      interface_busy_o <= 1'b1;
      info_page_select_o <= 1'b0;
    end else if (ce_i) begin
      main_readback_lock_o <= lock_r;
      interface_busy_o <= busy_r;
      info_page_select_o <= info_sel_r;
    end
  end

endmodule

`default_nettype wire

// ===== testbench/otp_config_status_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module otp_config_status_protect_tb
  import otp_cfg_pkg::*;
;
  localparam logic [39:0] DEV = 40'h3C5A96E1B2; // Arbitrary value
  localparam logic [8:0] A_ST = 9'h0F8;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, pwr_fail_i = 1'b0;
  logic sfr_wr_i = 1'b0, mcu_prog_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'hF8, sfr_wdata_i = 8'h00, mcu_data_i = 8'hFF;
  logic [15:0] mcu_addr_i = 16'h0000;
  logic [8:0] info_rd_addr_i = 9'h000;
  wire logic ser_cmd_i;
  wire logic [7:0] ser_opcode_i, ser_data_i;
  wire logic [15:0] ser_addr_i;
  logic [7:0] sfr_rdata_o, info_rdata_o, main_data_o, wr_data, md;
  logic [15:0] main_addr_o, wr_addr, ma;
  logic main_wr_o, main_readback_lock_o, interface_busy_o;
  logic info_page_select_o;
  int fails = 0, num_checks = 0, wr_cnt = 0, wr_base = 0;
  integer seed = 84;
  otp_config_status_protect #(.PROG_CYCLES(4), .DEVICE_NUMBER(DEV))
  i_otp_config_status_protect (
    .clk_i, .rst_n_i, .ce_i, .pwr_fail_i, .sfr_wr_i, .sfr_addr_i,
    .sfr_wdata_i, .sfr_rdata_o, .mcu_prog_i, .mcu_addr_i, .mcu_data_i,
    .ser_cmd_i, .ser_opcode_i, .ser_addr_i, .ser_data_i, .info_rd_addr_i,
    .info_rdata_o, .main_wr_o, .main_addr_o, .main_data_o,
    .main_readback_lock_o, .interface_busy_o, .info_page_select_o
  );
  otp_ser_model i_otp_ser_model (
    .clk_i, .busy_i(interface_busy_o), .ser_cmd_o(ser_cmd_i),
    .ser_opcode_o(ser_opcode_i), .ser_addr_o(ser_addr_i),
    .ser_data_o(ser_data_i)
  );
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (main_wr_o === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= main_addr_o;
      wr_data <= main_data_o;
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    sfr_addr_i <= OTP_STATUS_ADDR;
  endtask
  task automatic rd_chk(input logic info, input logic [8:0] a,
                        input logic [7:0] e);
    @(posedge clk_i);
    if (info) info_rd_addr_i <= a;
    else sfr_addr_i <= a[7:0];
    repeat (2) @(posedge clk_i);
    check(info ? info_rdata_o : sfr_rdata_o, e);
  endtask
  task automatic mcu(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    mcu_prog_i <= 1'b1;
    mcu_addr_i <= a;
    mcu_data_i <= d;
    @(posedge clk_i);
    mcu_prog_i <= 1'b0;
    mcu_addr_i <= ~a;
    mcu_data_i <= ~d;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 40 && interface_busy_o !== 1'b0; i++) @(posedge clk_i);
    check(8'(interface_busy_o), 8'h00);
  endtask
  task automatic ser(input logic [7:0] op, input logic [15:0] a);
    i_otp_ser_model.send(op, a, md);
  endtask
  task automatic expect_wr(input logic ok);
    check(8'(wr_cnt - wr_base), 8'(ok));
    if (ok) begin
      check(wr_addr[15:8], ma[15:8]);
      check(wr_addr[7:0], ma[7:0]);
      check(wr_data, md);
    end
    wr_base = wr_cnt;
  endtask
  task automatic rnd();
    ma = 16'($random(seed));
    md = 8'($random(seed));
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    do_reset();
    rd_chk(1'b0, A_ST, 8'h00);
    rd_chk(1'b0, 9'h0F9, PROTECT_CONFIG_VALUE);
    rd_chk(1'b0, 9'h0FA, COMMAND_RESET);
    rd_chk(1'b0, 9'h0C3, UNMAPPED_READ);
    for (int i = 0; i < ID_BYTES; i++)
      rd_chk(1'b1, ID_START + 9'(i), DEV[8*i +: 8]);
    rd_chk(1'b1, UNPROTECTED_PAGE_COUNT_BYTE, ERASED);
    rd_chk(1'b1, DATA_AREA_ENABLE_BYTE, DATA_AREA_ENABLE_VALUE);
    rd_chk(1'b1, 9'h022, ERASED);
    rd_chk(1'b1, LOCK_BYTE, ERASED);
    rd_chk(1'b1, USER_START + 9'($random(seed) & 8'hFF), ERASED);
    check(8'(main_readback_lock_o), 8'h00);
    sfr_wr(OTP_STATUS_ADDR, 8'hFF);
    rd_chk(1'b0, A_ST, 8'h08);
    check(8'(info_page_select_o), 8'h01);
    sfr_wr(OTP_PROTECT_CONFIG_ADDR, 8'h00);
    rd_chk(1'b0, 9'h0F9, PROTECT_CONFIG_VALUE);
    sfr_wr(OTP_COMMAND_ADDR, UNLOCK_FIRST);
    repeat (130) @(posedge clk_i);
    sfr_wr(OTP_COMMAND_ADDR, UNLOCK_SECOND);
    sfr_wr(OTP_STATUS_ADDR, 8'h20);
    rd_chk(1'b0, A_ST, 8'h00);
    sfr_wr(OTP_COMMAND_ADDR, UNLOCK_FIRST);
    sfr_wr(OTP_COMMAND_ADDR, UNLOCK_SECOND);
    sfr_wr(OTP_STATUS_ADDR, 8'h20);
    rd_chk(1'b0, A_ST, 8'h20);
    // Frozen clock enable must swallow a write that would clear WEN
    ce_i <= 1'b0;
    sfr_wr(OTP_STATUS_ADDR, 8'h08);
    ce_i <= 1'b1;
    rd_chk(1'b0, A_ST, 8'h20);
    rd_chk(1'b0, 9'h0FA, UNLOCK_SECOND);
    for (int k = 0; k < 4; k++) begin
      rnd();
      mcu(ma, md);
      expect_wr(1'b1);
    end
    sfr_wr(OTP_STATUS_ADDR, 8'h00);
    mcu(ma, md);
    expect_wr(1'b0);
    for (int k = 0; k < 4; k++) begin
      rnd();
      ser(CMD_WREN, ma);
      ser(CMD_PROGRAM, ma);
      expect_wr(1'b1);
      rd_chk(1'b0, A_ST, 8'h00);
    end
    ser(CMD_WREN, ma);
    ser(CMD_WRDIS, ma);
    ser(CMD_PROGRAM, ma);
    expect_wr(1'b0);
    pwr_fail_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    ser(CMD_WREN, ma);
    ser(CMD_PROGRAM, ma);
    expect_wr(1'b0);
    pwr_fail_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rnd();
    ser(CMD_WREN, ma);
    fork
      ser(CMD_PROGRAM, ma);
      begin
        repeat (3) @(posedge clk_i);
        pwr_fail_i <= 1'b1;
      end
    join
    expect_wr(1'b1);
    rd_chk(1'b0, A_ST, 8'h00);
    pwr_fail_i <= 1'b0;
    md = 8'h28;
    ser(CMD_WRSR, ma);
    rd_chk(1'b0, A_ST, 8'h28);
    md = 8'h5A;
    ser(CMD_PROGRAM, {7'h00, USER_START});
    expect_wr(1'b0);
    rd_chk(1'b1, USER_START, 8'h5A);
    md = 8'h28;
    ser(CMD_WRSR, ma);
    md = 8'hA5;
    ser(CMD_PROGRAM, {7'h00, USER_START});
    rd_chk(1'b1, USER_START, 8'h00);
    md = 8'h28;
    ser(CMD_WRSR, ma);
    mcu(16'h0101, 8'h00);
    rd_chk(1'b1, 9'h101, ERASED);
    mcu({7'h00, LOCK_BYTE}, 8'hF0);
    rd_chk(1'b1, LOCK_BYTE, 8'hF0);
    check(8'(main_readback_lock_o), 8'h00);
    // Lock from the unlocked state, byte 0x23 not yet all zero
    ser(CMD_WREN, ma);
    ser(CMD_LOCK, ma);
    check(8'(main_readback_lock_o), 8'h01);
    rd_chk(1'b1, LOCK_BYTE, 8'h00);
    rd_chk(1'b0, A_ST, 8'h0C);
    do_reset();
    check(8'(main_readback_lock_o), 8'h01);
    rd_chk(1'b0, A_ST, 8'h04);
    rd_chk(1'b0, 9'h0FA, COMMAND_RESET);
    rnd();
    ser(CMD_WREN, ma);
    ser(CMD_PROGRAM, ma);
    expect_wr(1'b0);
    ser(CMD_WREN, ma);
    ser(CMD_LOCK, ma);
    check(8'(main_readback_lock_o), 8'h01);
    rd_chk(1'b1, LOCK_BYTE, 8'h00);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== testbench/otp_csp_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checker
module otp_csp_props
  import otp_cfg_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Requests
  input wire logic pwr_fail_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic ser_cmd_i,
  input wire logic [7:0] ser_opcode_i,
  // Results
  input wire logic [7:0] sfr_rdata_o,
  input wire logic main_wr_o,
  input wire logic main_readback_lock_o,
  input wire logic interface_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] busy_run_r;
  // Run length instead of a long repetition
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !interface_busy_o) begin
      busy_run_r <= 16'h0000;
    end else begin
      busy_run_r <= busy_run_r + 16'h0001;
    end
  end
  property p_lock_sticky; !$fell(main_readback_lock_o); endproperty
  property p_lock_blocks; main_wr_o |-> !main_readback_lock_o; endproperty
  property p_protect_ro;
    sfr_addr_i == OTP_PROTECT_CONFIG_ADDR |=>
      sfr_rdata_o == PROTECT_CONFIG_VALUE;
  endproperty
  property p_reserved;
    sfr_addr_i == OTP_STATUS_ADDR |=>
      sfr_rdata_o[7:6] == 2'b00 && sfr_rdata_o[1:0] == 2'b00;
  endproperty
  property p_pwr_drop; pwr_fail_i [*4] |=> !main_wr_o; endproperty
  property p_busy_after; main_wr_o |=> interface_busy_o [*2]; endproperty
  property p_busy_bound; busy_run_r <= PROG_CYCLES + 1; endproperty
  property p_wen_clear;
    ser_cmd_i && ser_opcode_i == CMD_PROGRAM && !sfr_wr_i ##1
      sfr_addr_i == OTP_STATUS_ADDR && !sfr_wr_i && !ser_cmd_i
      |=> !sfr_rdata_o[WEN_BIT];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock flag cleared");
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("main write while locked");
  a_protect_ro: assert property (p_protect_ro)
    else $error("protect register not all ones");
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits set");
  a_pwr_drop: assert property (p_pwr_drop)
    else $error("main write during supply fail");
  a_busy_after: assert property (p_busy_after)
    else $error("busy missing after write");
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy too long");
  a_wen_clear: assert property (p_wen_clear)
    else $error("write enable kept after program");
  c_main_wr: cover property (main_wr_o);
  c_lock: cover property ($rose(main_readback_lock_o));
  c_pwr_busy: cover property (pwr_fail_i && interface_busy_o);
endmodule
bind otp_config_status_protect otp_csp_props #(
  .PROG_CYCLES(PROG_CYCLES)
) i_otp_csp_props (
  .clk_i, .rst_n_i, .pwr_fail_i, .sfr_wr_i, .sfr_addr_i, .ser_cmd_i,
  .ser_opcode_i, .sfr_rdata_o, .main_wr_o, .main_readback_lock_o,
  .interface_busy_o
);
`default_nettype wire

// ===== testbench/otp_ser_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial programmer model
module otp_ser_model (
  // Clock and status
  input wire logic clk_i,
  input wire logic busy_i,
  // Command hook
  output logic ser_cmd_o,
  output logic [7:0] ser_opcode_o,
  output logic [15:0] ser_addr_o,
  output logic [7:0] ser_data_o
);
  initial begin
    ser_cmd_o = 1'b0;
    ser_opcode_o = 8'h00;
    ser_addr_o = 16'h0000;
    ser_data_o = 8'h00;
  end
  task automatic send(input logic [7:0] op, input logic [15:0] a,
                      input logic [7:0] d);
    @(posedge clk_i);
    ser_cmd_o <= 1'b1;
    ser_opcode_o <= op;
    ser_addr_o <= a;
    ser_data_o <= d;
    @(posedge clk_i);
    ser_cmd_o <= 1'b0;
    // Released lines show garbage, not the last byte
    ser_opcode_o <= ~op;
    ser_addr_o <= ~a;
    ser_data_o <= ~d;
    repeat (3) @(posedge clk_i);
    // Next command only after the byte write is over
    for (int i = 0; i < 40 && busy_i !== 1'b0; i++) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire
